/* File: hdl/tmr_byte_counter.sv */
`timescale 1ns/1ps
`include "tmr_consts.svh"
// one 8-bit up counter with synchronous clear and carry
module tmr_byte_counter #(
    parameter int W = 8
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         run,
    input  wire logic         step,
    input  wire logic         clear,
    output logic [W-1:0]      count,
    output logic              carry
);
    assign carry = step && (count == {W{1'b1}});
    // stopped counter is cleared
    always_ff @(posedge aclk) begin
        if (!aresetn || !run)
            count <= '0;
        else if (clear)
            count <= '0;
        else if (step)
            count <= count + 1'b1;
    end
endmodule : tmr_byte_counter

/* File: hdl/tmr_consts.svh */
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH
// control registers keep their word index; byte address is four times it
`define TMR_IDX_LOWER_CTL    8'h16
`define TMR_IDX_UPPER_CTL    8'h17
`define TMR_ADDR_LOWER_CTL   (`TMR_IDX_LOWER_CTL << 2)
`define TMR_ADDR_UPPER_CTL   (`TMR_IDX_UPPER_CTL << 2)
`define TMR_ADDR_PERIOD      8'h20
`define TMR_ADDR_PWIDTH      8'h24
`define TMR_ADDR_STATUS      8'h28
`define TMR_ADDR_MISC        8'h2C
`define TMR_CTL_RESET        8'h00
`define TMR_FF_BIT           7
`define TMR_CK_HI            6
`define TMR_CK_LO            4
`define TMR_RUN_BIT          3
`define TMR_MODE_HI          2
`define TMR_MODE_LO          0
`define TMR_CK_FAST          3'h6
`define TMR_CK_PIN           3'h7
`define TMR_M_TIMER          3'h0
`define TMR_M_PDO            3'h1
`define TMR_M_PWM8           3'h2
`define TMR_M_16BIT          3'h3
`define TMR_M_T16            3'h4
`define TMR_M_WARM           3'h5
`define TMR_M_PWM16          3'h6
`define TMR_M_PPG            3'h7
`define TMR_DIV_W            11
`define TMR_RESP_OKAY        2'h0
`define TMR_RESP_SLVERR      2'h2
`endif

/* File: hdl/tmr_pkg.sv */
package tmr_pkg;
    // fields of one control register
    typedef struct packed {
        logic       flipflop_ctl;
        logic [2:0] clock_select;
        logic       run_control;
        logic [2:0] mode_select;
    } tmr_ctl_t;
    typedef enum logic [1:0] {
        TMR_PWR_NORMAL, TMR_PWR_IDLE, TMR_PWR_SLOW, TMR_PWR_SLEEP
    } tmr_pwr_t;
endpackage : tmr_pkg

/* File: hdl/tmr_tick_select.sv */
`timescale 1ns/1ps
`include "tmr_consts.svh"
// count source selection from prescaler taps and synchronised inputs
module tmr_tick_select #(
    parameter int DIV_W = `TMR_DIV_W
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [2:0]       clock_select,
    input  wire logic             divider_tap_select,
    input  wire logic             slow_mode,
    input  wire logic             warmup_mode,
    input  wire logic             slow_edge,
    input  wire logic             pin_edge,
    output logic                  tick
);
    logic [DIV_W-1:0] div;
    logic [DIV_W-1:0] div_d;
    logic [2:0]       slow_div;
    logic             slow_tap;
    logic             fast_ok;

    // free-running prescaler on the fast clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div   <= '0;
            div_d <= '0;
        end else begin
            div   <= div + 1'b1;
            div_d <= div;
        end
    end

    // slow clock divided by eight
    always_ff @(posedge aclk) begin
        if (!aresetn)
            slow_div <= 3'h0;
        else if (slow_edge)
            slow_div <= slow_div + 1'b1;
    end
    assign slow_tap = slow_edge && (slow_div == 3'h7);
    assign fast_ok  = !slow_mode; // fast taps dead in slow/sleep

    // tap falls: bit n 1->0 marks one tick per 2^(n+1)
    always_comb begin
        case (clock_select)
            3'h0: tick = (divider_tap_select || slow_mode) ? slow_tap
                         : (div_d[10] && !div[10]);
            3'h1: tick = fast_ok && div_d[6] && !div[6];
            3'h2: tick = fast_ok && div_d[4] && !div[4];
            3'h3: tick = fast_ok && div_d[2] && !div[2];
            3'h4: tick = slow_edge;
            3'h5: tick = fast_ok && div_d[0] && !div[0];
            `TMR_CK_FAST: tick = fast_ok || warmup_mode;
            default: tick = pin_edge;
        endcase
    end
endmodule : tmr_tick_select

/* File: hdl/tmr_timer_pair.sv */
`timescale 1ns/1ps
`include "tmr_consts.svh"
module tmr_timer_pair (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [7:0]   s_axi_awaddr,
    input  wire logic         s_axi_awvalid,
    output logic              s_axi_awready,
    input  wire logic [31:0]  s_axi_wdata,
    input  wire logic [3:0]   s_axi_wstrb,
    input  wire logic         s_axi_wvalid,
    output logic              s_axi_wready,
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  wire logic         s_axi_bready,
    input  wire logic [7:0]   s_axi_araddr,
    input  wire logic         s_axi_arvalid,
    output logic              s_axi_arready,
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  wire logic         s_axi_rready,
    input  wire logic         low_frequency_clock,
    input  wire logic         lower_pin,
    input  wire logic         upper_pin,
    output logic              lower_timer_out,
    output logic              upper_timer_out
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    tmr_pkg::tmr_ctl_t lower_timer_control;
    tmr_pkg::tmr_ctl_t upper_timer_control;
    logic [7:0]        upper_period_reg;
    logic [7:0]        upper_pulse_width_reg;
    logic [7:0]        lower_period_reg;
    logic [7:0]        lower_pulse_width_reg;
    logic              divider_tap_select;
    tmr_pkg::tmr_pwr_t power_mode;
    logic [2:0]        fs_sync;
    logic [2:0]        lp_sync;
    logic [2:0]        up_sync;
    logic              aw_held;
    logic              w_held;
    logic [7:0]        aw_addr;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              lower_ff;
    logic              upper_ff;
    logic              upper_run_q;
    logic              lower_run_q;

    // ------------------------------------------------------------
    // input synchronisers and edges
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fs_sync <= 3'h0;
            lp_sync <= 3'h0;
            up_sync <= 3'h0;
        end else begin
            fs_sync <= {fs_sync[1:0], low_frequency_clock};
            lp_sync <= {lp_sync[1:0], lower_pin};
            up_sync <= {up_sync[1:0], upper_pin};
        end
    end
    logic fs_edge, lp_edge, up_edge;
    assign fs_edge = fs_sync[1] && !fs_sync[2];
    assign lp_edge = lp_sync[1] && !lp_sync[2];
    assign up_edge = up_sync[1] && !up_sync[2];

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    logic       cascade;
    logic [2:0] eff_mode;
    logic       slow_mode;
    logic       lower_run;
    logic       upper_run;
    assign cascade   = lower_timer_control.mode_select == `TMR_M_16BIT;
    assign eff_mode  = cascade ? upper_timer_control.mode_select
                               : lower_timer_control.mode_select;
    assign slow_mode = power_mode == tmr_pkg::TMR_PWR_SLOW
                    || power_mode == tmr_pkg::TMR_PWR_SLEEP;
    assign lower_run = cascade ? upper_timer_control.run_control
                               : lower_timer_control.run_control;
    assign upper_run = upper_timer_control.run_control;

    // ------------------------------------------------------------
    // count sources
    // ------------------------------------------------------------
    logic lower_tick, upper_tick_8;
    tmr_tick_select u_lower_src (
        .aclk               (aclk),
        .aresetn            (aresetn),
        .clock_select       (lower_timer_control.clock_select),
        .divider_tap_select (divider_tap_select),
        .slow_mode          (slow_mode),
        .warmup_mode        (cascade && eff_mode == `TMR_M_WARM),
        .slow_edge          (fs_edge),
        .pin_edge           (lp_edge),
        .tick               (lower_tick)
    );
    tmr_tick_select u_upper_src (
        .aclk               (aclk),
        .aresetn            (aresetn),
        .clock_select       (upper_timer_control.clock_select),
        .divider_tap_select (divider_tap_select),
        .slow_mode          (slow_mode),
        .warmup_mode        (1'b0),
        .slow_edge          (fs_edge),
        .pin_edge           (up_edge),
        .tick               (upper_tick_8)
    );

    // ------------------------------------------------------------
    // counters
    // ------------------------------------------------------------
    logic [7:0] lower_count, upper_count;
    logic       lower_carry;
    logic       lower_match, upper_match, full_match, pw_match;
    logic       lower_clear, upper_clear;
    logic [15:0] count16;
    assign count16 = {upper_count, lower_count};
    assign lower_match = lower_tick && lower_count == lower_period_reg;
    assign upper_match = upper_tick_8 && upper_count == upper_period_reg;
    assign full_match  = lower_tick
        && count16 == {upper_period_reg, lower_period_reg};
    assign pw_match    = lower_tick
        && count16 == {upper_pulse_width_reg, lower_pulse_width_reg};
    assign lower_clear = cascade ? full_match : lower_match;
    assign upper_clear = cascade ? full_match : upper_match;

    tmr_byte_counter u_lower_cnt (
        .aclk    (aclk),
        .aresetn (aresetn),
        .run     (lower_run),
        .step    (lower_tick),
        .clear   (lower_clear),
        .count   (lower_count),
        .carry   (lower_carry)
    );
    tmr_byte_counter u_upper_cnt (
        .aclk    (aclk),
        .aresetn (aresetn),
        .run     (upper_run),
        .step    (cascade ? lower_carry : upper_tick_8),
        .clear   (upper_clear),
        .count   (upper_count),
        .carry   ()
    );

    // ------------------------------------------------------------
    // timer flip-flops and outputs
    // ------------------------------------------------------------
    // load on start; per mode, toggle on matches or set from the pulse-width compare
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lower_ff    <= 1'b0;
            lower_run_q <= 1'b0;
        end else begin
            lower_run_q <= lower_run;
            if (lower_run && !lower_run_q)
                lower_ff <= cascade ? upper_timer_control.flipflop_ctl
                                    : lower_timer_control.flipflop_ctl;
            else if (lower_run) begin
                case (eff_mode)
                    `TMR_M_PDO:   if (lower_match) lower_ff <= !lower_ff;
                    `TMR_M_PWM8:  if (lower_tick) lower_ff <=
                        lower_count < lower_pulse_width_reg;
                    `TMR_M_PWM16, `TMR_M_PPG: if (pw_match || full_match)
                        lower_ff <= !lower_ff;
                    `TMR_M_T16, `TMR_M_WARM: if (full_match)
                        lower_ff <= !lower_ff;
                    default:      lower_ff <= lower_ff;
                endcase
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            upper_ff    <= 1'b0;
            upper_run_q <= 1'b0;
        end else begin
            upper_run_q <= upper_run;
            if (upper_run && !upper_run_q)
                upper_ff <= upper_timer_control.flipflop_ctl;
            else if (upper_run && !cascade && upper_match)
                upper_ff <= !upper_ff;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lower_timer_out <= 1'b0;
            upper_timer_out <= 1'b0;
        end else begin
            lower_timer_out <= lower_ff;
            upper_timer_out <= cascade ? lower_ff : upper_ff;
        end
    end

    // ------------------------------------------------------------
    // axi4-lite write
    // ------------------------------------------------------------
    logic do_write;
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            aw_addr <= 8'h00;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held       <= 1'b1;
                s_axi_awready <= 1'b0;
                aw_addr <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held       <= 1'b0;
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held       <= 1'b1;
                s_axi_wready <= 1'b0;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (do_write) begin
                w_held       <= 1'b0;
                s_axi_wready <= 1'b1;
            end
        end
    end
    // register stores; control writes take effect at once, even on a running timer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lower_timer_control   <= `TMR_CTL_RESET;
            upper_timer_control   <= `TMR_CTL_RESET;
            upper_period_reg      <= 8'h00;
            upper_pulse_width_reg <= 8'h00;
            lower_period_reg      <= 8'h00;
            lower_pulse_width_reg <= 8'h00;
            divider_tap_select    <= 1'b0;
            power_mode            <= tmr_pkg::TMR_PWR_NORMAL;
        end else if (do_write && w_strb[0]) begin
            case (aw_addr)
                `TMR_ADDR_LOWER_CTL: lower_timer_control <= w_data[7:0];
                `TMR_ADDR_UPPER_CTL: upper_timer_control <= w_data[7:0];
                `TMR_ADDR_PERIOD: lower_period_reg <= w_data[7:0];
                `TMR_ADDR_PWIDTH: lower_pulse_width_reg <= w_data[7:0];
                `TMR_ADDR_MISC: begin
                    divider_tap_select <= w_data[0];
                    power_mode <= tmr_pkg::tmr_pwr_t'(w_data[2:1]);
                end
                default: ;
            endcase
            if (aw_addr == `TMR_ADDR_PERIOD && w_strb[1])
                upper_period_reg <= w_data[15:8];
            if (aw_addr == `TMR_ADDR_PWIDTH && w_strb[1])
                upper_pulse_width_reg <= w_data[15:8];
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `TMR_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr == `TMR_ADDR_LOWER_CTL
                || aw_addr == `TMR_ADDR_UPPER_CTL
                || aw_addr == `TMR_ADDR_PERIOD
                || aw_addr == `TMR_ADDR_PWIDTH
                || aw_addr == `TMR_ADDR_MISC
                || aw_addr == `TMR_ADDR_STATUS)
                ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
        end else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // ------------------------------------------------------------
    // axi4-lite read
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `TMR_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid
                && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `TMR_RESP_OKAY;
                case (s_axi_araddr)
                    `TMR_ADDR_LOWER_CTL: s_axi_rdata <=
                        {24'h000000, lower_timer_control};
                    `TMR_ADDR_UPPER_CTL: s_axi_rdata <=
                        {24'h000000, upper_timer_control};
                    `TMR_ADDR_PERIOD: s_axi_rdata <=
                        {16'h0000, upper_period_reg, lower_period_reg};
                    `TMR_ADDR_PWIDTH: s_axi_rdata <= {16'h0000,
                        upper_pulse_width_reg, lower_pulse_width_reg};
                    `TMR_ADDR_STATUS: s_axi_rdata <= {13'h0000, upper_ff,
                        lower_ff, upper_run, count16};
                    `TMR_ADDR_MISC: s_axi_rdata <=
                        {29'h00000000, power_mode, divider_tap_select};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `TMR_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule : tmr_timer_pair

/* File: test/test_eight_bit_timer_pair_control.sv */
`timescale 1ns/1ps
`include "tmr_consts.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED %s exp %0h seen %0h", nm, e, g); end end
module test_eight_bit_timer_pair_control;
    logic        aclk;
    logic        aresetn;
    logic [7:0]  s_axi_awaddr;
    logic        s_axi_awvalid;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_wvalid;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready;
    logic [7:0]  s_axi_araddr;
    logic        s_axi_arvalid;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready;
    logic        low_frequency_clock;
    logic        lower_pin;
    logic        upper_pin;
    logic        lower_timer_out;
    logic        upper_timer_out;
    int          n_fail;
    int          n_checks;
    logic [31:0] rd;
    logic [1:0]  rs;
    tmr_timer_pair dut_u (.*);
    // 10 MHz clock
    always #50 aclk = ~aclk;
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                             input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        `CHK("bresp", er, rs)
    endtask : axi_write
    task automatic axi_read(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_read
    // rising edges on the slow clock or on both pins
    task automatic pulse(input bit slow, input int n);
        repeat (n) begin
            @(posedge aclk);
            if (slow) low_frequency_clock <= 1'b1;
            else {lower_pin, upper_pin} <= 2'b11;
            repeat (3) @(posedge aclk);
            low_frequency_clock <= 1'b0;
            {lower_pin, upper_pin} <= 2'b00;
            repeat (3) @(posedge aclk);
        end
        repeat (6) @(posedge aclk);
    endtask : pulse
    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        tally_and_finish;
    end
    // main sequence
    initial begin
        {aclk, aresetn, s_axi_awaddr, s_axi_awvalid, s_axi_wdata} = '0;
        {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid} = '0;
        {s_axi_rready, low_frequency_clock, lower_pin, upper_pin} = '0;
        s_axi_wstrb = 4'hF;
        n_fail = 0;
        n_checks = 0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(`TMR_ADDR_LOWER_CTL);
        `CHK("lower reset", 8'h00, rd[7:0])
        axi_read(`TMR_ADDR_UPPER_CTL);
        `CHK("upper reset", 8'h00, rd[7:0])
        axi_read(8'h30);
        `CHK("rresp", `TMR_RESP_SLVERR, rs)
        axi_write(8'h30, 32'h0000_00FF, `TMR_RESP_SLVERR);
        axi_write(`TMR_ADDR_PERIOD, 32'h0000_FFFF, `TMR_RESP_OKAY);
        axi_write(`TMR_ADDR_PWIDTH, 32'h0000_8080, `TMR_RESP_OKAY);
        // pin source, flip-flop set by the starting write
        axi_write(`TMR_ADDR_LOWER_CTL, 32'h0000_00F8, `TMR_RESP_OKAY);
        axi_read(`TMR_ADDR_LOWER_CTL);
        `CHK("lower ctl", 8'hF8, rd[7:0])
        `CHK("lower out", 1'b1, lower_timer_out)
        pulse(1'b0, 5);
        axi_read(`TMR_ADDR_STATUS);
        `CHK("pin count", 16'h0005, rd[15:0])
        axi_write(`TMR_ADDR_LOWER_CTL, 32'h0000_00F0, `TMR_RESP_OKAY);
        axi_read(`TMR_ADDR_STATUS);
        `CHK("stop clear", 16'h0000, rd[15:0])
        axi_write(`TMR_ADDR_LOWER_CTL, 32'h0000_00C8, `TMR_RESP_OKAY);
        pulse(1'b1, 3);
        axi_read(`TMR_ADDR_STATUS);
        `CHK("slow count", 16'h0003, rd[15:0])
        axi_write(`TMR_ADDR_LOWER_CTL, 32'h0000_00C0, `TMR_RESP_OKAY);
        // eight-bit modes, flip-flop cleared at start
        for (int m = 0; m < 3; m++) begin
            axi_write(`TMR_ADDR_LOWER_CTL, {24'h0, 5'h0F, m[2:0]},
                      `TMR_RESP_OKAY);
            axi_read(`TMR_ADDR_LOWER_CTL);
            `CHK("lower mode", {5'h0F, m[2:0]}, rd[7:0])
            if (m == 0) `CHK("ff clear", 1'b0, lower_timer_out)
            axi_write(`TMR_ADDR_LOWER_CTL, {24'h0, 5'h0E, m[2:0]},
                      `TMR_RESP_OKAY);
        end
        // cascaded counter on the fast clock, run by upper control
        axi_write(`TMR_ADDR_LOWER_CTL, 32'h0000_0063, `TMR_RESP_OKAY);
        axi_write(`TMR_ADDR_UPPER_CTL, 32'h0000_008C, `TMR_RESP_OKAY);
        repeat (300) @(posedge aclk);
        axi_read(`TMR_ADDR_STATUS);
        `CHK("upper run", 1'b1, rd[16])
        `CHK("carry", 1'b1, rd[15:8] != 8'h00)
        `CHK("upper out", 1'b1, upper_timer_out)
        axi_write(`TMR_ADDR_UPPER_CTL, 32'h0000_0084, `TMR_RESP_OKAY);
        axi_read(`TMR_ADDR_STATUS);
        `CHK("cascade clear", 16'h0000, rd[15:0])
        for (int m = 4; m < 8; m++) begin
            axi_write(`TMR_ADDR_UPPER_CTL, {24'h0, 5'h11, m[2:0]},
                      `TMR_RESP_OKAY);
            axi_read(`TMR_ADDR_UPPER_CTL);
            `CHK("upper mode", {5'h11, m[2:0]}, rd[7:0])
            axi_write(`TMR_ADDR_UPPER_CTL, {24'h0, 5'h10, m[2:0]},
                      `TMR_RESP_OKAY);
        end
        // slow power: fast clock only as warm-up counter
        axi_write(`TMR_ADDR_MISC, 32'h0000_0004, `TMR_RESP_OKAY);
        axi_write(`TMR_ADDR_UPPER_CTL, 32'h0000_008C, `TMR_RESP_OKAY);
        repeat (50) @(posedge aclk);
        axi_read(`TMR_ADDR_STATUS);
        `CHK("slow no tick", 16'h0000, rd[15:0])
        axi_write(`TMR_ADDR_UPPER_CTL, 32'h0000_0084, `TMR_RESP_OKAY);
        axi_write(`TMR_ADDR_UPPER_CTL, 32'h0000_008D, `TMR_RESP_OKAY);
        repeat (50) @(posedge aclk);
        axi_read(`TMR_ADDR_STATUS);
        `CHK("warm-up ticks", 1'b1, rd[15:0] != 16'h0000)
        // both timers as pin-driven dividers, periods 2 and 3
        axi_write(`TMR_ADDR_UPPER_CTL, 32'h0000_0085, `TMR_RESP_OKAY);
        axi_write(`TMR_ADDR_PERIOD, 32'h0000_0302, `TMR_RESP_OKAY);
        axi_write(`TMR_ADDR_LOWER_CTL, 32'h0000_0079, `TMR_RESP_OKAY);
        axi_write(`TMR_ADDR_UPPER_CTL, 32'h0000_0079, `TMR_RESP_OKAY);
        pulse(1'b0, 5);
        axi_read(`TMR_ADDR_STATUS);
        `CHK("pin pair status", 19'h70102, rd[18:0])
        `CHK("pair out", 2'b11, {lower_timer_out, upper_timer_out})
        tally_and_finish;
    end
endmodule : test_eight_bit_timer_pair_control

/* File: test/tmr_timer_pair_sva.sv */
`timescale 1ns/1ps
`include "tmr_consts.svh"
// ----------------------------------------------
// bus and output checks at the timer pair pins
// ----------------------------------------------
module tmr_timer_pair_sva (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        lower_timer_out,
    input wire logic        upper_timer_out
);
    default clocking dc @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    logic wr_hs;
    logic ar_hs;
    // address and write handshake held together
    assign wr_hs = s_axi_awvalid && s_axi_awready &&
                   s_axi_wvalid && s_axi_wready;
    assign ar_hs = s_axi_arvalid && s_axi_arready;
    function automatic logic unmapped(input logic [7:0] a);
        unmapped = !(a inside {`TMR_ADDR_LOWER_CTL, `TMR_ADDR_UPPER_CTL,
            `TMR_ADDR_PERIOD, `TMR_ADDR_PWIDTH, `TMR_ADDR_STATUS,
            `TMR_ADDR_MISC});
    endfunction : unmapped
    property p_reset_out;
        $rose(aresetn) |-> !lower_timer_out && !upper_timer_out;
    endproperty
    property p_write_answer;
        wr_hs |=> !s_axi_awready ##1 s_axi_bvalid;
    endproperty
    property p_bresp_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_rdata_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_read_ok;
        ar_hs && !unmapped(s_axi_araddr) |=>
            s_axi_rvalid && s_axi_rresp == `TMR_RESP_OKAY;
    endproperty
    property p_read_err;
        ar_hs && unmapped(s_axi_araddr) |=>
            s_axi_rvalid && s_axi_rresp == `TMR_RESP_SLVERR;
    endproperty
    property p_write_err;
        wr_hs && unmapped(s_axi_awaddr) |->
            ##2 s_axi_bvalid && s_axi_bresp == `TMR_RESP_SLVERR;
    endproperty
    property p_arready_pulse;
        ar_hs |=> !s_axi_arready;
    endproperty
    a_reset_out: assert property (p_reset_out)
        else $error("timer outputs high after reset");
    a_write_answer: assert property (p_write_answer)
        else $error("write answer late or early");
    a_bresp_hold: assert property (p_bresp_hold)
        else $error("write response dropped");
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data dropped");
    a_read_ok: assert property (p_read_ok)
        else $error("mapped read not answered okay");
    a_read_err: assert property (p_read_err)
        else $error("unmapped read not refused");
    a_write_err: assert property (p_write_err)
        else $error("unmapped write not refused");
    a_arready_pulse: assert property (p_arready_pulse)
        else $error("read address ready held");
    c_write: cover property (wr_hs);
    c_read_err: cover property (ar_hs && unmapped(s_axi_araddr));
    c_upper_out: cover property ($rose(upper_timer_out));
endmodule : tmr_timer_pair_sva

bind tmr_timer_pair tmr_timer_pair_sva chk_u (.*);
